// ### core/idle_timer_regs.vh
// register map, field positions, reset values and counts of the idle wakeup timer
`ifndef IDLE_TIMER_REGS_VH
`define IDLE_TIMER_REGS_VH

// ----------------------------------------------------------------
// register word indices; the byte address is four times the index
// ----------------------------------------------------------------
`define OFS_IDLE_MODE      6'h00
`define OFS_IRQ_CONTROL    6'h01
`define OFS_IRQ_STATUS     6'h02
`define OFS_IRQ_MASK       6'h03

// ----------------------------------------------------------------
// idle_mode_reg fields
// ----------------------------------------------------------------
`define MODE_SEL_LSB       0
`define MODE_SEL_MSB       2
`define MODE_RSVD_BIT      3
`define MODE_CORE_CLK_BIT  4
`define MODE_DUAL_CLK_BIT  5
`define MODE_HIGH_OSC_BIT  6
`define MODE_LOW_OSC_BIT   7
`define MODE_CLK_LSB       4
`define MODE_RESET_VAL     8'h40
`define MODE_CLK_KILL      4'h0

// ----------------------------------------------------------------
// irq_control_reg fields
// ----------------------------------------------------------------
`define CTRL_GLOBAL_EN_BIT 0
`define CTRL_EN_BIT        4
`define CTRL_PEND_BIT      5

// ----------------------------------------------------------------
// interrupt status and mask fields
// ----------------------------------------------------------------
`define STAT_TICK_BIT      0

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define CORE_CLK_HZ        20000000
`define SLOW_CLK_HZ        32768
`define INSTR_DIV          10
`define TAP_BASE_BIT       11
`define SEL_TOP_CODE       3'h4
`define COUNT_WIDTH        16

`endif

// ### core/idle_timebase_counter.v
// free-running down counter with selectable underflow tap
`timescale 1ns/10ps
`include "idle_timer_regs.vh"

module idle_timebase_counter #(
	parameter WIDTH    = `COUNT_WIDTH,
	parameter TAP_BASE = `TAP_BASE_BIT
) (
	input  wire             core_clk,
	input  wire             resetn,
	input  wire             countEn,
	input  wire [2:0]       periodSel,
	output reg              tapUnderflow_ff
);

	// ----------------------------------------------------------------
	// tap mask
	// ----------------------------------------------------------------
	// ones from bit 0 up to the selected tap; reserved codes act as the top tap
	function [WIDTH-1:0] lowMask;
		input [2:0] sel;
		integer     top;
		integer     i;
		begin
			top = TAP_BASE + ((sel > `SEL_TOP_CODE) ? 4 : sel);
			for (i = 0; i < WIDTH; i = i + 1) begin
				lowMask[i] = (i <= top);
			end
		end
	endfunction

	reg  [WIDTH-1:0] count_ff;
	wire [WIDTH-1:0] nxt_count;
	wire             wrapNow;

	// ----------------------------------------------------------------
	// counting
	// ----------------------------------------------------------------
	// the tap underflows when every bit up to it is zero and a step arrives
	assign wrapNow   = countEn && ((count_ff & lowMask(periodSel)) == {WIDTH{1'b0}});
	assign nxt_count = countEn ? (count_ff - {{(WIDTH-1){1'b0}}, 1'b1}) : count_ff;

	// counter is hidden from software; it only runs and flags its tap
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			count_ff        <= {WIDTH{1'b1}};
			tapUnderflow_ff <= 1'b0;
		end else begin
			count_ff        <= nxt_count;
			tapUnderflow_ff <= wrapNow;
		end
	end

endmodule // idle_timebase_counter

// ### core/idle_wakeup_timer.v
// idle wakeup timer top: ahb-lite registers, clock selection, tick and interrupt logic
//
// Functional notes
// - idle timebase is a hidden sixteen-bit down counter, no software access
// - high-speed mode counts instruction cycles, one fifth of crystal frequency
// - dual-clock or low-speed mode counts the 32 kHz slow clock instead
// - divide-by-ten instruction stage is halted while the slow clock is used
// - underflow of the selected tap bit, 11 to 15, sets the pending flag
// - each tap underflow also clears port G bit 6 to leave idle
// - interrupt request needs pending flag, tick enable and global enable together
// - pending flag is control bit 5, tick enable is control bit 4
// - period select codes 0 to 4 give 4096 doubling to 65536 clocks
// - reset clears period select, giving the shortest 4096-cycle period
// - writing zeros to mode bits 7 to 4 requests a device reset
`timescale 1ns/10ps
`include "idle_timer_regs.vh"

module idle_wakeup_timer #(
	parameter INSTR_DIV = `INSTR_DIV
) (
	input  wire        core_clk,
	input  wire        resetn,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg         hresp,
	output reg  [31:0] hrdata,
	// 32 kHz slow clock pin, sampled
	input  wire        slowClkPin,
	// outputs to the core
	output reg         idleIrqReq_ff,
	output reg         irq_ff,
	output reg         portG6Clear_ff,
	output reg         deviceResetReq_ff,
	output reg         instrTick_ff
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	localparam DIV_W = 4;
	localparam [DIV_W-1:0] DIV_LAST = INSTR_DIV - 1;

	reg  [7:0]       idleModeReg_ff;
	reg              pending_ff;
	reg              tickEnable_ff;
	reg              globalEnable_ff;
	reg              statusTick_ff;
	reg              maskTick_ff;
	reg  [DIV_W-1:0] divCnt_ff;
	reg              slowSync1_ff;
	reg              slowSync2_ff;
	reg              slowPrev_ff;
	reg              wrPend_ff;
	reg  [5:0]       wrIndex_ff;

	reg  [31:0]      readMux;
	reg              nxt_pending;
	reg              nxt_statusTick;
	reg  [DIV_W-1:0] nxt_divCnt;

	wire             addrPhase;
	wire             wrMode;
	wire             wrCtrl;
	wire             wrStatus;
	wire             wrMask;
	wire             slowMode;
	wire             slowRise;
	wire             instrStep;
	wire             countEn;
	wire             tapUnderflow;
	wire [2:0]       periodSel;

	// ----------------------------------------------------------------
	// slow clock synchroniser
	// ----------------------------------------------------------------
	// two flops bring the pin into the core domain; a third finds the edge
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			slowSync1_ff <= 1'b0;
			slowSync2_ff <= 1'b0;
			slowPrev_ff  <= 1'b0;
		end else begin
			slowSync1_ff <= slowClkPin;
			slowSync2_ff <= slowSync1_ff;
			slowPrev_ff  <= slowSync2_ff;
		end
	end

	assign slowRise = slowSync2_ff & ~slowPrev_ff;

	// ----------------------------------------------------------------
	// clock mode selection
	// ----------------------------------------------------------------
	// dual-clock enable or core clock select both move the timebase to the slow clock
	assign slowMode  = idleModeReg_ff[`MODE_DUAL_CLK_BIT] | idleModeReg_ff[`MODE_CORE_CLK_BIT];
	assign periodSel = idleModeReg_ff[`MODE_SEL_MSB:`MODE_SEL_LSB];

	// ----------------------------------------------------------------
	// instruction cycle divider
	// ----------------------------------------------------------------
	// core_clk is twice the crystal rate, so a divide by ten yields one fifth of it
	always @* begin
		if (slowMode) begin
			nxt_divCnt = {DIV_W{1'b0}};
		end else if (divCnt_ff == DIV_LAST) begin
			nxt_divCnt = {DIV_W{1'b0}};
		end else begin
			nxt_divCnt = divCnt_ff + {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end

	assign instrStep = ~slowMode && (divCnt_ff == DIV_LAST);

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			divCnt_ff    <= {DIV_W{1'b0}};
			instrTick_ff <= 1'b0;
		end else begin
			divCnt_ff    <= nxt_divCnt;
			instrTick_ff <= instrStep;
		end
	end

	// pick the step source for the timebase
	assign countEn = slowMode ? slowRise : instrStep;

	// ----------------------------------------------------------------
	// timebase counter
	// ----------------------------------------------------------------
	idle_timebase_counter #(
		.WIDTH    (`COUNT_WIDTH),
		.TAP_BASE (`TAP_BASE_BIT)
	) idle_timebase_counter_inst (
		.core_clk        (core_clk),
		.resetn          (resetn),
		.countEn         (countEn),
		.periodSel       (periodSel),
		.tapUnderflow_ff (tapUnderflow)
	);

	// ----------------------------------------------------------------
	// ahb-lite address and data phase
	// ----------------------------------------------------------------
	// a transfer is taken when selected, nonsequential or sequential, and ready
	assign addrPhase = hsel && htrans[1] && hready;

	// latch the write target for the data phase; reads are answered at once
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wrPend_ff  <= 1'b0;
			wrIndex_ff <= 6'h00;
			hrdata     <= 32'h00000000;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end else begin
			wrPend_ff  <= addrPhase && hwrite;
			wrIndex_ff <= haddr[7:2];
			hrdata     <= (addrPhase && !hwrite) ? readMux : 32'h00000000;
			hreadyout  <= 1'b1;                                 // never waits
			hresp      <= 1'b0;                                 // always okay
		end
	end

	// data-phase write strobes by register index
	assign wrMode   = wrPend_ff && (wrIndex_ff == `OFS_IDLE_MODE);
	assign wrCtrl   = wrPend_ff && (wrIndex_ff == `OFS_IRQ_CONTROL);
	assign wrStatus = wrPend_ff && (wrIndex_ff == `OFS_IRQ_STATUS);
	assign wrMask   = wrPend_ff && (wrIndex_ff == `OFS_IRQ_MASK);

	// ----------------------------------------------------------------
	// read multiplexer
	// ----------------------------------------------------------------
	// the counter itself has no address; unmapped offsets read zero
	always @* begin
		readMux = 32'h00000000;
		case (haddr[7:2])
			`OFS_IDLE_MODE: begin
				readMux[7:0] = idleModeReg_ff;
			end
			`OFS_IRQ_CONTROL: begin
				readMux[`CTRL_PEND_BIT] = pending_ff;
				readMux[`CTRL_EN_BIT]   = tickEnable_ff;
				readMux[`CTRL_GLOBAL_EN_BIT] = globalEnable_ff;
			end
			`OFS_IRQ_STATUS: begin
				readMux[`STAT_TICK_BIT] = statusTick_ff;
			end
			`OFS_IRQ_MASK: begin
				readMux[`STAT_TICK_BIT] = maskTick_ff;
			end
			default: begin
				readMux = 32'h00000000;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// idle mode register
	// ----------------------------------------------------------------
	// bit 3 is kept at zero whatever is written, so it cannot serve as a flag
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			idleModeReg_ff    <= `MODE_RESET_VAL;
			deviceResetReq_ff <= 1'b0;
		end else begin
			if (wrMode) begin
				idleModeReg_ff[7:`MODE_CLK_LSB]              <= hwdata[7:`MODE_CLK_LSB];
				idleModeReg_ff[`MODE_RSVD_BIT]               <= 1'b0;
				idleModeReg_ff[`MODE_SEL_MSB:`MODE_SEL_LSB]  <= hwdata[2:0];
			end
			// zeros in all four clock-control bits kill the oscillators: reset
			deviceResetReq_ff <= wrMode && (hwdata[7:`MODE_CLK_LSB] == `MODE_CLK_KILL);
		end
	end

	// ----------------------------------------------------------------
	// pending flag and enables
	// ----------------------------------------------------------------
	// a tap underflow in the same cycle as a clear keeps the flag set
	always @* begin
		nxt_pending = pending_ff;
		if (wrCtrl && hwdata[`CTRL_PEND_BIT]) begin
			nxt_pending = 1'b0;
		end
		if (tapUnderflow) begin
			nxt_pending = 1'b1;
		end
	end

	// a period change may wrap the tap early; software masks and clears around it
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pending_ff      <= 1'b0;
			tickEnable_ff   <= 1'b0;
			globalEnable_ff <= 1'b0;
		end else begin
			pending_ff <= nxt_pending;
			if (wrCtrl) begin
				tickEnable_ff   <= hwdata[`CTRL_EN_BIT];
				globalEnable_ff <= hwdata[`CTRL_GLOBAL_EN_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt status and mask
	// ----------------------------------------------------------------
	// sticky tick event, cleared by writing one, set beats clear
	always @* begin
		nxt_statusTick = statusTick_ff;
		if (wrStatus && hwdata[`STAT_TICK_BIT]) begin
			nxt_statusTick = 1'b0;
		end
		if (tapUnderflow) begin
			nxt_statusTick = 1'b1;
		end
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			statusTick_ff <= 1'b0;
			maskTick_ff   <= 1'b0;
		end else begin
			statusTick_ff <= nxt_statusTick;
			if (wrMask) begin
				maskTick_ff <= hwdata[`STAT_TICK_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs to the core
	// ----------------------------------------------------------------
	// the core request, the masked summary line and the idle exit pulse
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			idleIrqReq_ff  <= 1'b0;
			irq_ff         <= 1'b0;
			portG6Clear_ff <= 1'b0;
		end else begin
			idleIrqReq_ff  <= pending_ff & tickEnable_ff & globalEnable_ff;
			irq_ff         <= statusTick_ff & maskTick_ff;
			portG6Clear_ff <= tapUnderflow;
		end
	end

endmodule // idle_wakeup_timer

// ### sim/idle_wakeup_timer_properties.sv
// port-level property checker for the idle wakeup timer
`timescale 1ns/10ps
module idle_wakeup_timer_check #(
	parameter INSTR_DIV = 10
) (
	input wire        core_clk,
	input wire        resetn,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [2:0]  hsize,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire        hreadyout,
	input wire        hresp,
	input wire [31:0] hrdata,
	input wire        slowClkPin,
	input wire        idleIrqReq_ff,
	input wire        irq_ff,
	input wire        portG6Clear_ff,
	input wire        deviceResetReq_ff,
	input wire        instrTick_ff
);
	// accepted transfers in their address phase
	wire        wrA    = hsel & htrans[1] & hready & hwrite;
	wire        rdA    = hsel & htrans[1] & hready & ~hwrite;
	wire        modeWr = wrA & (haddr[7:0] == 8'h00);
	reg  [15:0] gap_ff;
	reg         seen_ff;
	reg         modeWrD_ff;

	// cycles since the last instruction tick; a mode write restarts the spacing
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			gap_ff     <= 16'h0;
			seen_ff    <= 1'b0;
			modeWrD_ff <= 1'b0;
		end else begin
			modeWrD_ff <= modeWr;
			if (instrTick_ff) begin
				gap_ff  <= 16'h0;
				seen_ff <= ~modeWrD_ff;
			end else begin
				gap_ff <= gap_ff + 16'h1;
				if (modeWrD_ff) begin
					seen_ff <= 1'b0;
				end
			end
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	AST_BUS_OKAY: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
	AST_COUNT_HIDDEN: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits");
	AST_RDATA_PHASE: assert property (hrdata != 32'h0 |-> $past(rdA))
		else $error("read data outside data phase");
	AST_INSTR_GAP: assert property (instrTick_ff && seen_ff |-> gap_ff == INSTR_DIV - 1)
		else $error("instruction tick spacing");
	AST_WAKE_PULSE: assert property (portG6Clear_ff |=> (!portG6Clear_ff) [*8])
		else $error("wake pulse too long");
	AST_RESET_REQ: assert property (modeWr ##1 hwdata[7:4] == 4'h0 |=> deviceResetReq_ff)
		else $error("reset request missing");
	AST_RESET_CAUSE: assert property ($rose(deviceResetReq_ff) |-> $past(modeWr, 2))
		else $error("reset request without mode write");
	AST_IRQ_CAUSE: assert property ($rose(idleIrqReq_ff) |-> $past(portG6Clear_ff) || $past(wrA, 3))
		else $error("interrupt request without cause");
	AST_IRQ_HOLD: assert property ($fell(idleIrqReq_ff) |-> $past(wrA, 3))
		else $error("interrupt request dropped alone");
	AST_STAT_CAUSE: assert property ($rose(irq_ff) |-> $past(portG6Clear_ff) || $past(wrA, 3))
		else $error("interrupt without cause");
endmodule // idle_wakeup_timer_check

bind idle_wakeup_timer idle_wakeup_timer_check #(.INSTR_DIV(INSTR_DIV)) idle_wakeup_timer_check_inst (
	.core_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
	.hresp, .hrdata, .slowClkPin, .idleIrqReq_ff, .irq_ff, .portG6Clear_ff, .deviceResetReq_ff,
	.instrTick_ff
);

// ### sim/idle_wakeup_timer_bench.sv
// self-checking bench for the idle wakeup timer
`timescale 1ns/10ps
`include "idle_timer_regs.vh"
module idle_wakeup_timer_bench;
	localparam [31:0] AMODE = {24'h0, `OFS_IDLE_MODE, 2'h0};
	localparam [31:0] ACTL  = {24'h0, `OFS_IRQ_CONTROL, 2'h0};
	localparam [31:0] ASTAT = {24'h0, `OFS_IRQ_STATUS, 2'h0};
	localparam [31:0] AMASK = {24'h0, `OFS_IRQ_MASK, 2'h0};
	logic        core_clk   = 1'b0;
	logic        resetn     = 1'b0;
	logic [31:0] haddr      = 32'h0;
	logic [1:0]  htrans     = 2'h0;
	logic        hwrite     = 1'b0;
	logic [31:0] hwdata     = 32'h0;
	logic        slowClkPin = 1'b0;
	logic        slowOn     = 1'b0;
	logic [31:0] cyc        = 32'h0;
	logic [31:0] tickCnt    = 32'h0;
	logic [31:0] rstCnt     = 32'h0;
	logic [31:0] tickAt;
	logic [31:0] rdat;
	logic [31:0] t1;
	wire         hreadyout;
	wire         hresp;
	wire  [31:0] hrdata;
	wire         idleIrqReq_ff;
	wire         irq_ff;
	wire         portG6Clear_ff;
	wire         deviceResetReq_ff;
	wire         instrTick_ff;
	integer      bad_count  = 0;
	integer      checks     = 0;
	integer      i;

	// divider shortened to two core clocks per instruction cycle
	idle_wakeup_timer #(.INSTR_DIV(2)) idle_wakeup_timer_inst (
		.core_clk, .resetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .slowClkPin, .idleIrqReq_ff, .irq_ff,
		.portG6Clear_ff, .deviceResetReq_ff, .instrTick_ff
	);

	initial begin
		forever #25 core_clk = ~core_clk;
	end

	// cycle count and event tallies
	always @(posedge core_clk) begin
		cyc <= cyc + 32'h1;
		if (portG6Clear_ff === 1'b1) tickCnt <= tickCnt + 32'h1;
		if (deviceResetReq_ff === 1'b1) rstCnt <= rstCnt + 32'h1;
	end

	// slow clock, period six core clocks, only while enabled
	always begin
		@(posedge core_clk);
		if (slowOn) begin
			repeat (2) @(posedge core_clk);
			slowClkPin <= ~slowClkPin;
		end
	end

	task cmpWord(input [31:0] got, input [31:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("unexpected at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask

	task ahb(input [31:0] a, input w, input [31:0] d);
		begin
			haddr <= a;
			hwrite <= w;
			htrans <= 2'h2;
			@(posedge core_clk);
			while (hreadyout !== 1'b1) @(posedge core_clk);
			htrans <= 2'h0;
			hwdata <= d;
			@(posedge core_clk);
			while (hreadyout !== 1'b1) @(posedge core_clk);
			rdat = hrdata;
		end
	endtask

	task wr(input [31:0] a, input [31:0] d);
		ahb(a, 1'b1, d);
	endtask

	task rd(input [31:0] a, input [31:0] exp);
		begin
			ahb(a, 1'b0, 32'h0);
			cmpWord(rdat, exp);
		end
	endtask

	task waitTick;
		begin
			@(posedge core_clk);
			while (portG6Clear_ff !== 1'b1) @(posedge core_clk);
			tickAt = cyc;
		end
	endtask

	task countInstr(input integer n, input [31:0] exp);
		begin
			t1 = 32'h0;
			repeat (n) begin
				@(posedge core_clk);
				if (instrTick_ff === 1'b1) t1 = t1 + 32'h1;
			end
			cmpWord(t1, exp);
		end
	endtask

	task regReset;
		begin
			rd(AMODE, 32'h40);
			rd(ACTL, 32'h0);
			rd(ASTAT, 32'h0);
			rd(AMASK, 32'h0);
			wr(32'h10, 32'hFF);
			rd(32'h10, 32'h0);
			wr(AMODE, 32'h48);
			rd(AMODE, 32'h40);
			for (i = 1; i < 8; i = i + 1) begin
				wr(AMODE, 32'h40 | i);
				rd(AMODE, 32'h40 | i);
			end
			wr(AMODE, 32'h40);
		end
	endtask

	// tick, pending flag, interrupt gating and the base period
	task tickIrq;
		begin
			wr(ACTL, 32'h30);
			waitTick;
			t1 = tickAt;
			repeat (3) @(posedge core_clk);
			rd(ACTL, 32'h30);
			rd(ASTAT, 32'h1);
			cmpWord(idleIrqReq_ff, 1'b0);
			cmpWord(irq_ff, 1'b0);
			wr(ACTL, 32'h11);
			wr(AMASK, 32'h1);
			repeat (3) @(posedge core_clk);
			cmpWord(idleIrqReq_ff, 1'b1);
			cmpWord(irq_ff, 1'b1);
			repeat (1000) @(posedge core_clk);
			rd(ACTL, 32'h31);
			waitTick;
			cmpWord(tickAt - t1, 32'h2000);
			wr(ACTL, 32'h31);
			wr(ASTAT, 32'h1);
			repeat (3) @(posedge core_clk);
			cmpWord(idleIrqReq_ff, 1'b0);
			cmpWord(irq_ff, 1'b0);
		end
	endtask

	// period doubling after a masked select change
	task periodTwo;
		begin
			wr(ACTL, 32'h01);
			wr(AMODE, 32'h41);
			wr(ACTL, 32'h21);
			waitTick;
			t1 = tickAt;
			waitTick;
			cmpWord(tickAt - t1, 32'h4000);
		end
	endtask

	task resetReq;
		begin
			t1 = rstCnt;
			wr(AMODE, 32'h10);
			wr(AMODE, 32'h00);
			repeat (3) @(posedge core_clk);
			cmpWord(rstCnt - t1, 32'h1);
		end
	endtask

	// slow clock mode: no count while the slow pin stands
	task slowMode;
		begin
			wr(AMODE, 32'h60);
			repeat (3) @(posedge core_clk);
			countInstr(50, 32'h0);
			t1 = tickCnt;
			repeat (9000) @(posedge core_clk);
			cmpWord(tickCnt - t1, 32'h0);
			slowOn = 1'b1;
			t1 = cyc;
			waitTick;
			cmpWord(tickAt - t1 <= 32'h6010, 1'b1);
		end
	endtask

	task tally_and_finish;
		begin
			if (bad_count == 0 && checks > 0) begin
				$display("All tests passed");
			end else begin
				$display("Some tests failed");
			end
			$finish;
		end
	endtask

	initial begin
		repeat (100000) @(posedge core_clk);
		bad_count = bad_count + 1;
		tally_and_finish;
	end

	initial begin
		repeat (5) @(posedge core_clk);
		resetn <= 1'b1;
		regReset;
		countInstr(20, 32'hA);
		tickIrq;
		periodTwo;
		resetReq;
		slowMode;
		tally_and_finish;
	end
endmodule // idle_wakeup_timer_bench
